/* common/afc_consts.svh */
// Register offsets, field positions and timing counts of the fault control
`ifndef AFC_CONSTS_SVH
`define AFC_CONSTS_SVH
`define AFC_REG_MODE        3'h0
`define AFC_REG_DIAG        3'h1
`define AFC_REG_MASK        3'h2
`define AFC_REG_GAIN_A      3'h3
`define AFC_REG_GAIN_B      3'h4
`define AFC_BIT_INPUT_A     2
`define AFC_BIT_INPUT_B     3
`define AFC_BIT_ACTIVE      4
`define AFC_BIT_CURRENT_LIMIT_SELECT      1
`define AFC_BIT_CLEAR       2
`define AFC_BIT_REPEAT      3
`define AFC_BIT_TRIGGER     4
`define AFC_REPEAT_MS       60
`define AFC_CLK_MHZ         100
`define AFC_REPEAT_CYCLES   (`AFC_REPEAT_MS * 1000 * `AFC_CLK_MHZ)
`define AFC_STEP_CYCLES     16
`endif

/* common/afc_pkg.sv */
// Types shared by the fault control block
package afc_pkg;
    typedef struct packed {
        logic thermal;
        logic overcurrent;
        logic supply_short;
        logic open_load;
        logic bridge_short;
    } afc_fault_t;
    typedef struct packed {
        logic       we;
        logic [2:0] addr;
        logic [7:0] data;
    } afc_wr_t;
endpackage

/* core/afc_core.sv */
// Control registers, diagnostic sequencer and fault flag of the amplifier
`timescale 1ns/1ns
`default_nettype none
`include "afc_consts.svh"

module afc_core #(
    parameter int REPEAT_CYCLES = `AFC_REPEAT_CYCLES,
    parameter int STEP_CYCLES   = `AFC_STEP_CYCLES
) (
    input  wire logic                I_REF_CLK,
    input  wire logic                I_SYS_RST,
    input  wire logic                I_CLK_EN,
    input  wire afc_pkg::afc_wr_t    I_WR,
    input  wire afc_pkg::afc_fault_t I_SENSE,
    output logic                     O_SEL_A,
    output logic                     O_SEL_B,
    output logic                     O_MUTE,
    output logic                     O_OUT_EN,
    output logic                     O_SHUTDOWN,
    output logic                     O_CURRENT_LIMIT_SELECT_SUPPLY,
    output logic [4:0]               O_GAIN_A,
    output logic [4:0]               O_GAIN_B,
    output logic                     O_DIAG_BUSY,
    output logic [1:0]               O_TEST_SEL,
    output logic                     O_FAULT_N_OUT,
    output logic                     O_FAULT_N_OE
);
    import afc_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SUPPLY, ST_BRIDGE, ST_OPEN, ST_WAIT
    } afc_state_t;

    // Diagnostic test selector codes seen by the analog front end
    localparam logic [1:0] TS_NONE   = 2'h0;
    localparam logic [1:0] TS_SUPPLY = 2'h1;
    localparam logic [1:0] TS_BRIDGE = 2'h2;
    localparam logic [1:0] TS_OPEN   = 2'h3;

    afc_state_t  state;
    afc_state_t  next_state;
    logic [7:0]  mode_control;
    logic [7:0]  diagnostic_control;
    logic [7:0]  fault_mask_control;
    logic [4:0]  first_input_gain;
    logic [4:0]  second_gain_code;
    logic        powerup;
    logic [7:0]  pend_data [0:4];
    logic [4:0]  pend_mask;
    logic        pend_valid;
    logic [2:0]  pend_idx;
    afc_wr_t     pend;
    logic        protect_hit;
    logic        fault_flag;
    logic        trig_armed;
    logic        clear_prev;
    logic [31:0] timer;
    logic [31:0] next_timer;
    afc_fault_t  sense_s1;
    afc_fault_t  sense_s2;

    // Sensor comparators are asynchronous to the clock
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            sense_s1 <= '0;
            sense_s2 <= '0;
        end else if (I_CLK_EN) begin
            sense_s1 <= I_SENSE;
            sense_s2 <= sense_s1;
        end
    end

    // Lowest register still holding a deferred write
    function automatic logic [2:0] first_held(input logic [4:0] m);
        logic [2:0] idx;
        idx = 3'h0;
        for (int k = 4; k >= 0; k--) begin
            if (m[k]) begin
                idx = 3'(k);
            end
        end
        return idx;
    endfunction

    // Held writes drain one per cycle, lowest register first
    assign pend_valid = |pend_mask;
    assign pend_idx   = first_held(pend_mask);
    assign pend       = '{we:   1'b1,
                          addr: pend_idx,
                          data: pend_data[pend_idx]};

    // Write path; new writes queue behind the run and any backlog
    wire logic    hold_on     = powerup || pend_valid;
    wire logic    addr_ok     = I_WR.addr <= `AFC_REG_GAIN_B;
    wire logic    wr_now      = I_WR.we && !hold_on;
    wire logic    wr_defer    = I_WR.we && hold_on && addr_ok;
    wire afc_wr_t wr_apply    = wr_now ? I_WR : pend;
    wire logic    apply_valid = wr_now || (!powerup && pend_valid);
    wire logic    abort_pu    = powerup && I_WR.we
                                && I_WR.addr == `AFC_REG_DIAG
                                && I_WR.data[`AFC_BIT_CLEAR];

    wire logic wr_diag = apply_valid && wr_apply.addr == `AFC_REG_DIAG;
    wire logic new_trig  = wr_apply.data[`AFC_BIT_TRIGGER];
    wire logic new_clear = wr_apply.data[`AFC_BIT_CLEAR];
    wire logic old_trig  = diagnostic_control[`AFC_BIT_TRIGGER];
    wire logic repeat_on = diagnostic_control[`AFC_BIT_REPEAT];

    // Edge detect on the stored trigger bit
    wire logic trig_rise = wr_diag && new_trig && !old_trig;
    wire logic clear_tgl = wr_diag && (new_clear != clear_prev);
    wire logic repeat_off = wr_diag
                            && !wr_apply.data[`AFC_BIT_REPEAT];

    // Faults: protection acts always, flag only through the mask
    wire logic in_test = state == ST_SUPPLY || state == ST_BRIDGE
                         || state == ST_OPEN;
    wire afc_fault_t active_fault = '{
        thermal:      sense_s2.thermal,
        overcurrent:  sense_s2.overcurrent,
        supply_short: sense_s2.supply_short && state == ST_SUPPLY,
        open_load:    sense_s2.open_load && state == ST_OPEN,
        bridge_short: sense_s2.bridge_short && state == ST_BRIDGE
    };
    wire logic any_fault = |active_fault;
    wire logic flag_fault = |(active_fault
                              & ~fault_mask_control[4:0]);

    // Sequencer steps: supply, bridge, open; repeat waits
    always_comb begin
        next_state = state;
        next_timer = timer + 32'h0000_0001;
        case (state)
            ST_IDLE: begin
                next_timer = '0;
                if (trig_rise) begin
                    next_state = ST_SUPPLY;
                end
            end
            ST_SUPPLY: begin
                if (timer == STEP_CYCLES - 1) begin
                    next_state = ST_BRIDGE;
                    next_timer = '0;
                end
            end
            ST_BRIDGE: begin
                if (timer == STEP_CYCLES - 1) begin
                    next_state = ST_OPEN;
                    next_timer = '0;
                end
            end
            ST_OPEN: begin
                if (timer == STEP_CYCLES - 1) begin
                    next_timer = '0;
                    next_state = (repeat_on && !powerup)
                                 ? ST_WAIT : ST_IDLE;
                end
            end
            ST_WAIT: begin
                if (timer == REPEAT_CYCLES - 1) begin
                    next_state = ST_SUPPLY;
                    next_timer = '0;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // Continuous mode stops on fault, clear toggle or repeat off
        if (state != ST_IDLE && (any_fault || abort_pu || clear_tgl
                                 || (repeat_off && !powerup))) begin
            next_state = ST_IDLE;
            next_timer = '0;
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            state <= ST_SUPPLY;
            timer <= '0;
        end else if (I_CLK_EN) begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    // Power-up run ends when sequencer returns idle
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            powerup   <= 1'b1;
            pend_mask <= 5'h00;
            pend_data <= '{default: 8'h00};
        end else if (I_CLK_EN) begin
            if (powerup && next_state == ST_IDLE) begin
                powerup <= 1'b0;
            end
            // Drained slot freed first so a newer write to it survives
            if (!powerup && pend_valid) begin
                pend_mask[pend_idx] <= 1'b0;
            end
            if (wr_defer) begin
                pend_mask[I_WR.addr] <= 1'b1;
                pend_data[I_WR.addr] <= I_WR.data;
            end
        end
    end

    // Register file: reserved bits never stored
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            mode_control       <= 8'h00;
            diagnostic_control <= 8'h00;
            fault_mask_control <= 8'h00;
            first_input_gain   <= 5'h00;
            second_gain_code   <= 5'h00;
            clear_prev         <= 1'b0;
        end else if (I_CLK_EN && apply_valid) begin
            case (wr_apply.addr)
                `AFC_REG_MODE:   mode_control <= wr_apply.data
                                                 & 8'h1C;
                `AFC_REG_DIAG: begin
                    diagnostic_control <= wr_apply.data & 8'h1E;
                    clear_prev         <= new_clear;
                end
                `AFC_REG_MASK:   fault_mask_control <= wr_apply.data
                                                       & 8'h1F;
                `AFC_REG_GAIN_A: first_input_gain <= wr_apply.data[4:0];
                `AFC_REG_GAIN_B: second_gain_code <= wr_apply.data[4:0];
                default: begin
                end
            endcase
        end
    end

    // Fault latches; a new fault wins over a clear in the same cycle
    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            protect_hit <= 1'b0;
            fault_flag  <= 1'b0;
        end else if (I_CLK_EN) begin
            if (any_fault) begin
                protect_hit <= 1'b1;
            end else if (clear_tgl) begin
                protect_hit <= 1'b0;
            end
            if (flag_fault) begin
                fault_flag <= 1'b1;
            end else if (clear_tgl) begin
                fault_flag <= 1'b0;
            end
        end
    end

    wire logic sel_a   = mode_control[`AFC_BIT_INPUT_A];
    wire logic sel_b   = mode_control[`AFC_BIT_INPUT_B];
    wire logic active  = mode_control[`AFC_BIT_ACTIVE] && !powerup;
    wire logic outs_on = active && !protect_hit && !any_fault
                         && !in_test;

    always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_SEL_A         <= 1'b0;
            O_SEL_B         <= 1'b0;
            O_MUTE          <= 1'b1;
            O_OUT_EN        <= 1'b0;
            O_SHUTDOWN      <= 1'b1;
            O_CURRENT_LIMIT_SELECT_SUPPLY <= 1'b0;
            O_GAIN_A        <= 5'h00;
            O_GAIN_B        <= 5'h00;
            O_DIAG_BUSY     <= 1'b1;
            O_TEST_SEL      <= TS_NONE;
            O_FAULT_N_OUT   <= 1'b0;
            O_FAULT_N_OE    <= 1'b0;
        end else if (I_CLK_EN) begin
            O_SEL_A         <= sel_a;
            O_SEL_B         <= sel_b;
            O_MUTE          <= !sel_a && !sel_b;
            O_OUT_EN        <= outs_on;
            O_SHUTDOWN      <= !active;
            O_CURRENT_LIMIT_SELECT_SUPPLY <= diagnostic_control[`AFC_BIT_CURRENT_LIMIT_SELECT];
            O_GAIN_A        <= first_input_gain;
            O_GAIN_B        <= second_gain_code;
            O_DIAG_BUSY     <= next_state != ST_IDLE
                               && next_state != ST_WAIT;
            O_TEST_SEL      <= next_state == ST_SUPPLY ? TS_SUPPLY :
                               next_state == ST_BRIDGE ? TS_BRIDGE :
                               next_state == ST_OPEN   ? TS_OPEN : TS_NONE;
            O_FAULT_N_OUT   <= 1'b0;
            O_FAULT_N_OE    <= fault_flag || flag_fault;
        end
    end

    // Checks
    sequence s_flag_set;
        I_CLK_EN && flag_fault;
    endsequence

    a_flag_latch: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST) s_flag_set |=> fault_flag)
        else $error("flag not latched");
    a_flag_hold: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST) fault_flag && !clear_tgl && I_CLK_EN
        |=> fault_flag)
        else $error("flag dropped without clear");
    a_prot_disable: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST) I_CLK_EN && any_fault |=> !O_OUT_EN)
        else $error("outputs on during fault");
    a_mute_none: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST) I_CLK_EN && !sel_a && !sel_b |=> O_MUTE)
        else $error("not muted");
    a_shut_off: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST) O_SHUTDOWN |-> !O_OUT_EN)
        else $error("outputs on in shutdown");
    a_pu_defer: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST) I_CLK_EN && wr_defer |=> pend_valid)
        else $error("write during power-up lost");
    a_trig_start: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST) I_CLK_EN && state == ST_IDLE && trig_rise
        && !any_fault && !clear_tgl |=> state == ST_SUPPLY)
        else $error("trigger edge did not start tests");
    a_open_only: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST) active_fault.open_load |-> state == ST_OPEN)
        else $error("open-load outside sequence");
    a_mask_quiet: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST) I_CLK_EN && !fault_flag
        && (active_fault & ~fault_mask_control[4:0]) == 5'h00
        |=> !O_FAULT_N_OE)
        else $error("flag pulled without unmasked fault");
    a_pu_shut: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST) I_CLK_EN && powerup |=> O_SHUTDOWN)
        else $error("amplifier awake during power-up run");
    a_held_drain: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST) I_CLK_EN && !powerup && pend_valid
        && !wr_defer |=> pend_mask != $past(pend_mask))
        else $error("held write not applied");
    a_clear_rel: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST) I_CLK_EN && clear_tgl && !flag_fault
        |=> !fault_flag)
        else $error("flag kept after clear toggle");
    a_repeat_stop: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST) I_CLK_EN && state != ST_IDLE
        && repeat_off && !powerup |=> state == ST_IDLE)
        else $error("sequence kept running after repeat cleared");
    a_heat_flag: assert property (@(posedge I_REF_CLK)
        disable iff (I_SYS_RST) I_CLK_EN && sense_s2.thermal
        && !fault_mask_control[4] |=> fault_flag && !O_OUT_EN)
        else $error("thermal overload not flagged");
endmodule

`default_nettype wire

/* verification/afc_host_model.sv */
// Host model that writes the fault control registers
`timescale 1ns/1ns
`default_nettype none
module afc_host_model (
    input  wire logic            i_clk,
    output var afc_pkg::afc_wr_t o_wr
);
    import afc_pkg::*;
    logic clr = 1'b0;
    initial o_wr = '{1'b0, 3'h7, 8'hFF};
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1 o_wr = '{1'b1, a, d};
        @(posedge i_clk);
        #1 o_wr = '{1'b0, ~a, ~d};
    endtask
    // Clear bit kept as last written, so it toggles only on purpose
    task automatic diag(input logic rep, input logic trig, input logic lim);
        wr(3'h1, {3'b000, trig, rep, clr, lim, 1'b0});
    endtask
    task automatic start(input logic rep);
        diag(rep, 1'b0, 1'b0);
        diag(rep, 1'b1, 1'b0);
    endtask
    task automatic clear_fault();
        clr = ~clr;
        diag(1'b0, 1'b0, 1'b0);
    endtask
    task automatic abort_run();
        clr = 1'b1;
        diag(1'b0, 1'b0, 1'b0);
    endtask
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench of the amplifier fault control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import afc_pkg::*;
    localparam int STEP = 4;
    localparam int REP  = 50;
    localparam int RUN  = 3 * STEP + 8;
    logic             clk;
    logic             rst;
    logic             ce;
    afc_wr_t          wr;
    afc_fault_t       sense;
    logic             sel_a, sel_b, mute, out_en, sd, ilim, busy, f_out, f_oe;
    logic [4:0]       gain_a, gain_b;
    logic [1:0]       tsel;
    int               err_total = 0;
    int               n_tests = 0;
    wire logic [4:0]  st = {sel_a, sel_b, mute, sd, out_en};
    wire logic [1:0]  flt = {out_en, f_oe};

    afc_core #(.REPEAT_CYCLES(REP), .STEP_CYCLES(STEP)) u_dut (
        .I_REF_CLK(clk), .I_SYS_RST(rst), .I_CLK_EN(ce), .I_WR(wr),
        .I_SENSE(sense), .O_SEL_A(sel_a), .O_SEL_B(sel_b), .O_MUTE(mute),
        .O_OUT_EN(out_en), .O_SHUTDOWN(sd), .O_CURRENT_LIMIT_SELECT_SUPPLY(ilim),
        .O_GAIN_A(gain_a), .O_GAIN_B(gain_b), .O_DIAG_BUSY(busy),
        .O_TEST_SEL(tsel), .O_FAULT_N_OUT(f_out), .O_FAULT_N_OE(f_oe)
    );
    afc_host_model u_host (.i_clk(clk), .o_wr(wr));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wait_busy(input logic v, input int lim);
        for (int k = 0; k < lim && busy !== v; k++) cyc(1);
        chk("busy level", {15'h0, v}, {15'h0, busy});
    endtask
    task automatic idle_chk(input int n);
        logic any;
        any = 1'b0;
        repeat (n) begin
            cyc(1);
            any = any | busy;
        end
        chk("busy idle", 16'h0, {15'h0, any});
    endtask

    task automatic t_power();
        logic [3:0] seen;
        seen = '0;
        chk("reset outputs", 16'h06, {10'h0, f_oe, st});
        rst = 1'b0;
        u_host.wr(3'h0, 8'h1C);
        seen[tsel] = 1'b1;
        u_host.wr(3'h4, 8'h0B);
        chk("shutdown in run", 16'h1, {15'h0, sd});
        for (int k = 0; k < RUN && busy === 1'b1; k++) begin
            seen[tsel] = 1'b1;
            cyc(1);
        end
        chk("power-up steps", 16'h7, {13'h0, seen[3:1]});
        cyc(4);
        chk("deferred mode", 16'h19, {11'h0, st});
        chk("deferred gain", 16'h0B, {11'h0, gain_b});
        $display("test power-up done");
    endtask

    task automatic t_mux();
        logic [2:0]  v;
        logic [15:0] e;
        for (int m = 0; m < 8; m++) begin
            v = m[2:0];
            u_host.wr(3'h0, {3'b000, v, 2'b11});
            cyc(1);
            e = {11'h0, v[0], v[1], ~|v[1:0], ~v[2], v[2]};
            chk("mode outputs", e, {11'h0, st});
        end
        u_host.diag(1'b0, 1'b0, 1'b1);
        cyc(1);
        chk("limit select", 16'h1, {15'h0, ilim});
        u_host.diag(1'b0, 1'b0, 1'b0);
        cyc(1);
        chk("limit select", 16'h0, {15'h0, ilim});
        u_host.wr(3'h3, 8'hF5);
        u_host.wr(3'h4, 8'hEA);
        u_host.wr(3'h5, 8'h00);
        cyc(1);
        chk("gain codes", 16'h02AA, {6'h0, gain_a, gain_b});
        $display("test mode and gain done");
    endtask

    task automatic t_freeze();
        ce = 1'b0;
        u_host.wr(3'h0, 8'h00);
        cyc(2);
        chk("frozen mode", 16'h19, {11'h0, st});
        ce = 1'b1;
        cyc(2);
        chk("thawed mode", 16'h19, {11'h0, st});
        $display("test clock enable done");
    endtask

    task automatic t_oneshot();
        u_host.wr(3'h2, 8'h1F);
        u_host.start(1'b0);
        cyc(1);
        chk("trigger start", 16'h1, {14'h0, tsel});
        wait_busy(1'b0, RUN);
        u_host.diag(1'b0, 1'b1, 1'b0);
        idle_chk(RUN);
        u_host.start(1'b0);
        cyc(1);
        chk("rerun", 16'h1, {15'h0, busy});
        wait_busy(1'b0, RUN);
        u_host.wr(3'h2, 8'h00);
        $display("test one-shot done");
    endtask

    task automatic t_fault();
        logic mk;
        u_host.diag(1'b0, 1'b0, 1'b0);
        for (int i = 0; i < 5; i++) begin
            for (int j = 0; j < 2; j++) begin
                mk = j[0];
                u_host.wr(3'h2, 8'(mk) << i);
                sense = afc_fault_t'(5'h01 << i);
                cyc(4);
                if (i < 3) begin
                    chk("untested fault", 16'h2, {14'h0, flt});
                    u_host.start(1'b0);
                    wait_busy(1'b0, RUN);
                end
                chk("fault out", {15'h0, ~mk}, {14'h0, flt});
                chk("fault pin level", 16'h0, {15'h0, f_out});
                sense = '0;
                cyc(4);
                chk("fault held", {15'h0, ~mk}, {14'h0, flt});
                u_host.clear_fault();
                cyc(2);
                chk("fault cleared", 16'h2, {14'h0, flt});
            end
        end
        u_host.wr(3'h2, 8'h00);
        $display("test faults done");
    endtask

    task automatic t_repeat();
        int k;
        u_host.start(1'b1);
        cyc(1);
        wait_busy(1'b0, RUN);
        for (k = 0; k < REP + 20 && busy !== 1'b1; k++) cyc(1);
        chk("repeat gap", 16'h1, {15'h0, k >= REP - 2 && k <= REP + 1});
        u_host.diag(1'b0, 1'b1, 1'b0);
        cyc(1);
        chk("repeat stop", 16'h0, {15'h0, busy});
        idle_chk(REP + 20);
        $display("test continuous done");
    endtask

    task automatic t_abort();
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(1);
        chk("run after reset", 16'h3, {14'h0, busy, sd});
        u_host.abort_run();
        wait_busy(1'b0, 2);
        $display("test abort done");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        sense = '0;
        repeat (5) @(posedge clk);
        #1;
        t_power();
        t_mux();
        t_freeze();
        t_oneshot();
        t_fault();
        t_repeat();
        t_abort();
        report_and_stop();
    end

    // Cuts a hang short well past the expected run length
    initial begin
        #100000;
        err_total++;
        $display("unexpected watchdog: expected done seen hang");
        report_and_stop();
    end
endmodule
`default_nettype wire
